/* logic/bccr_pkg.sv */
// Package for the bridge chip control register bank: offsets, fields, reset values, timer figures.
// Assumes a 50 MHz core clock; discard timer lengths are in PCI clocks, counted on an enable.
package bccr_pkg;
  localparam logic [7:0]  CC0_OFFSET     = 8'h40;
  localparam logic [31:0] CC0_RESET      = 32'h0920_0000;
  localparam logic [31:0] CC0_WR_MASK    = 32'h3ffe_8000;
  localparam int          FC_BIT         = 15;
  localparam int          RSTAT_BIT      = 16;
  localparam int          RLIM_LSB       = 17;
  localparam int          DDIS_BIT       = 19;
  localparam int          DSHORT_BIT     = 20;
  localparam int          CRS_LSB        = 21;
  localparam int          DTORD_BIT      = 23;
  localparam int          CPL_LSB        = 24;
  localparam int          ISO_BIT        = 26;
  localparam int          TC_LSB         = 27;
  localparam int          LOOP_BIT       = 30;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam logic [31:0] RLIM_256       = 32'h0000_0100;
  localparam logic [31:0] RLIM_64K       = 32'h0001_0000;
  localparam logic [31:0] RLIM_2G        = 32'h8000_0000;
  localparam int          DISC_SHORT_CLK = 64;
  localparam int          CRS_T0_NS      = 25000;
  localparam int          CRS_T1_NS      = 500000;
  localparam int          CRS_T2_NS      = 5000000;
  localparam int          CRS_T3_NS      = 25000000;
  localparam int          CPL_T0_NS      = 50000;
  localparam int          CPL_T1_NS      = 10000000;
  localparam int          CPL_T2_NS      = 50000000;
  localparam int          CRS_C0         = CRS_T0_NS / CLK_PERIOD_NS;
  localparam int          CRS_C1         = CRS_T1_NS / CLK_PERIOD_NS;
  localparam int          CRS_C2         = CRS_T2_NS / CLK_PERIOD_NS;
  localparam int          CRS_C3         = CRS_T3_NS / CLK_PERIOD_NS;
  localparam int          CPL_C0         = CPL_T0_NS / CLK_PERIOD_NS;
  localparam int          CPL_C1         = CPL_T1_NS / CLK_PERIOD_NS;
  localparam int          CPL_C2         = CPL_T2_NS / CLK_PERIOD_NS;
  localparam int          DISC_LONG_CLK  = 32768;
  localparam int          DISC_MID_CLK   = 1024;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bccr_cfg_req_t;
endpackage

/* logic/bccr_top.sv */
// Chip control register at configuration offset 40h with the timers and counters it steers.
// Assumes one config request per cycle and one outstanding job per timer at a time.
// Contract
// - Bit 15 clear: update every two credits; set: every credit; resets zero.
// - Bit 16 sets on retry counter expiry, cleared by writing one, resets zero.
// - Bits 18:17 pick retry limit: none, 256, 64K, 2G; reset 00.
// - Bit 19 clear enables discard timer with bridge control bit 27; reset zero. Code runs the timer on bit 19 clear alone; bit 27 only gates SERR.
// - Short duration bit set: discard timer expires after 64 PCI clocks.
// - Short bit clear: length from 3Ch bit 24 forward, bit 25 reverse.
// - Config retry timer code: 25us, 0.5ms, 5ms, 25ms; resets to 01.
// - Order bit clear allows out-of-order delayed completions; set forces order.
// - Completion timeout code: 50us, 10ms, 50ms, disabled; resets to 01.
// - Isochronous bit clear maps PCI-to-PCIe memory to TC0, else bits 29:27.
// - Isochronous traffic class field is writable and resets to 001.
// - Serial link mode zero is normal; writable only in some configurations.
// - Link mode bit loops transmitter to receiver under test strap; RO forward.
module bccr_top #(
  parameter int CRS_C1_P   = bccr_pkg::CRS_C1,
  parameter int CRS_C2_P   = bccr_pkg::CRS_C2,
  parameter int CRS_C3_P   = bccr_pkg::CRS_C3,
  parameter int CPL_C1_P   = bccr_pkg::CPL_C1,
  parameter int CPL_C2_P   = bccr_pkg::CPL_C2,
  parameter int DISC_LONG_P = bccr_pkg::DISC_LONG_CLK
) (
  input  wire logic                   core_clk_in,     // Core clock
  input  wire logic                   rst_in,          // Async reset, high
  input  wire bccr_pkg::bccr_cfg_req_t cfg_req_in,     // Config access
  output logic [31:0]                 cfg_rdata_out,   // Read data
  output logic                        cfg_rvalid_out,  // Read data valid
  input  wire logic                   reverse_mode_in, // Reverse bridge mode
  input  wire logic                   test_strap_in,   // Loopback strap combo met
  input  wire logic [2:0]             bctl_in,         // Bridge ctl bits 27,25,24
  input  wire logic                   credit_in,       // One credit freed
  output logic                        fc_update_out,   // Send flow-control update
  input  wire logic                   retry_in,        // Target retry of pending txn
  input  wire logic                   txn_done_in,     // Pending txn finished
  input  wire logic                   pci_clk_en_in,   // PCI clock tick
  input  wire logic                   disc_start_in,   // Start discard timer
  input  wire logic                   disc_stop_in,    // Stop discard timer
  output logic                        disc_exp_out,    // Discard timer expired
  output logic                        disc_serr_out,   // Expiry with SERR enabled
  input  wire logic                   crs_start_in,    // Start config retry timer
  input  wire logic                   crs_stop_in,     // Stop config retry timer
  output logic                        crs_exp_out,     // Config retry expired
  input  wire logic                   cpl_start_in,    // Start completion timer
  input  wire logic                   cpl_stop_in,     // Stop completion timer
  output logic                        cpl_exp_out,     // Completion timeout
  output logic                        dt_in_order_out, // Keep delayed txns in order
  output logic [2:0]                  tc_out,          // Traffic class for upstream mem
  output logic                        loopback_out     // Serial link loopback active
);
  logic [31:0] reg_r, reg_nxt;
  logic [31:0] rcnt_r, rcnt_nxt;
  logic [15:0] dcnt_r, dcnt_nxt;
  logic [21:0] crs_r, crs_nxt;
  logic [21:0] cpl_r, cpl_nxt;
  logic        fc_half_r, fc_half_nxt;
  logic [31:0] rdata_nxt;
  logic        rexp;
  logic        disc_exp_nxt, crs_exp_nxt, cpl_exp_nxt, fc_upd_nxt;
  logic [31:0] bmask;
  logic        hit_wr;

  function automatic logic [31:0] retry_limit(input logic [1:0] sel);
    case (sel)
      2'b01:   retry_limit = bccr_pkg::RLIM_256;
      2'b10:   retry_limit = bccr_pkg::RLIM_64K;
      2'b11:   retry_limit = bccr_pkg::RLIM_2G;
      default: retry_limit = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [21:0] crs_load(input logic [1:0] sel);
    case (sel)
      2'b00:   crs_load = 22'(bccr_pkg::CRS_C0);
      2'b01:   crs_load = 22'(CRS_C1_P);
      2'b10:   crs_load = 22'(CRS_C2_P);
      default: crs_load = 22'(CRS_C3_P);
    endcase
  endfunction

  function automatic logic [21:0] cpl_load(input logic [1:0] sel);
    case (sel)
      2'b00:   cpl_load = 22'(bccr_pkg::CPL_C0);
      2'b01:   cpl_load = 22'(CPL_C1_P);
      2'b10:   cpl_load = 22'(CPL_C2_P);
      default: cpl_load = 22'h00_0000;
    endcase
  endfunction

  always_comb begin
    bmask  = {{8{cfg_req_in.be[3]}}, {8{cfg_req_in.be[2]}}, {8{cfg_req_in.be[1]}}, {8{cfg_req_in.be[0]}}};
    hit_wr = cfg_req_in.wr && (cfg_req_in.addr == bccr_pkg::CC0_OFFSET);
    reg_nxt = reg_r;
    if (hit_wr) begin
      reg_nxt = (reg_r & ~(bccr_pkg::CC0_WR_MASK & bmask)) |
                (cfg_req_in.wdata & bccr_pkg::CC0_WR_MASK & bmask);
      if (reverse_mode_in && test_strap_in && bmask[bccr_pkg::LOOP_BIT])
        reg_nxt[bccr_pkg::LOOP_BIT] = cfg_req_in.wdata[bccr_pkg::LOOP_BIT];
      if (bmask[bccr_pkg::RSTAT_BIT] && cfg_req_in.wdata[bccr_pkg::RSTAT_BIT])
        reg_nxt[bccr_pkg::RSTAT_BIT] = 1'b0;
    end
    // Loopback is read-only zero while forward
    if (!reverse_mode_in)
      reg_nxt[bccr_pkg::LOOP_BIT] = 1'b0;
    // Retry counting; limit 00 never expires
    rcnt_nxt = rcnt_r;
    rexp     = 1'b0;
    if (txn_done_in) begin
      rcnt_nxt = 32'h0000_0000;
    end else if (retry_in) begin
      rcnt_nxt = rcnt_r + 32'h0000_0001;
      if (retry_limit(reg_r[bccr_pkg::RLIM_LSB +: 2]) != 32'h0000_0000 &&
          rcnt_nxt >= retry_limit(reg_r[bccr_pkg::RLIM_LSB +: 2])) begin
        rexp     = 1'b1;
        rcnt_nxt = 32'h0000_0000;
      end
    end
    // Set beats a same-cycle software clear
    if (rexp)
      reg_nxt[bccr_pkg::RSTAT_BIT] = 1'b1;
    // Discard timer in PCI clocks
    dcnt_nxt     = dcnt_r;
    disc_exp_nxt = 1'b0;
    if (disc_stop_in || reg_r[bccr_pkg::DDIS_BIT]) begin
      dcnt_nxt = 16'h0000;
    end else if (disc_start_in) begin
      if (reg_r[bccr_pkg::DSHORT_BIT])
        dcnt_nxt = 16'(bccr_pkg::DISC_SHORT_CLK);
      else if (reverse_mode_in ? bctl_in[1] : bctl_in[0])
        dcnt_nxt = 16'(bccr_pkg::DISC_MID_CLK);
      else
        dcnt_nxt = 16'(DISC_LONG_P);
    end else if (pci_clk_en_in && dcnt_r != 16'h0000) begin
      dcnt_nxt     = dcnt_r - 16'h0001;
      disc_exp_nxt = (dcnt_r == 16'h0001);
    end
    // Config retry and completion timers
    crs_nxt     = crs_r;
    crs_exp_nxt = 1'b0;
    if (crs_stop_in)
      crs_nxt = 22'h00_0000;
    else if (crs_start_in)
      crs_nxt = crs_load(reg_r[bccr_pkg::CRS_LSB +: 2]);
    else if (crs_r != 22'h00_0000) begin
      crs_nxt     = crs_r - 22'h00_0001;
      crs_exp_nxt = (crs_r == 22'h00_0001);
    end
    cpl_nxt     = cpl_r;
    cpl_exp_nxt = 1'b0;
    if (cpl_stop_in)
      cpl_nxt = 22'h00_0000;
    else if (cpl_start_in)
      cpl_nxt = cpl_load(reg_r[bccr_pkg::CPL_LSB +: 2]);
    else if (cpl_r != 22'h00_0000) begin
      cpl_nxt     = cpl_r - 22'h00_0001;
      cpl_exp_nxt = (cpl_r == 22'h00_0001);
    end
    // Credit granularity
    fc_half_nxt = fc_half_r;
    fc_upd_nxt  = 1'b0;
    if (credit_in) begin
      if (reg_r[bccr_pkg::FC_BIT] || fc_half_r) begin
        fc_upd_nxt  = 1'b1;
        fc_half_nxt = 1'b0;
      end else begin
        fc_half_nxt = 1'b1;
      end
    end
    rdata_nxt = (cfg_req_in.rd && cfg_req_in.addr == bccr_pkg::CC0_OFFSET) ? reg_r : 32'h0000_0000;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_r           <= bccr_pkg::CC0_RESET;
      rcnt_r          <= 32'h0000_0000;
      dcnt_r          <= 16'h0000;
      crs_r           <= 22'h00_0000;
      cpl_r           <= 22'h00_0000;
      fc_half_r       <= 1'b0;
      cfg_rdata_out   <= 32'h0000_0000;
      cfg_rvalid_out  <= 1'b0;
      fc_update_out   <= 1'b0;
      disc_exp_out    <= 1'b0;
      disc_serr_out   <= 1'b0;
      crs_exp_out     <= 1'b0;
      cpl_exp_out     <= 1'b0;
      dt_in_order_out <= 1'b0;
      tc_out          <= 3'h0;
      loopback_out    <= 1'b0;
    end else begin
      reg_r           <= reg_nxt;
      rcnt_r          <= rcnt_nxt;
      dcnt_r          <= dcnt_nxt;
      crs_r           <= crs_nxt;
      cpl_r           <= cpl_nxt;
      fc_half_r       <= fc_half_nxt;
      cfg_rdata_out   <= rdata_nxt;
      cfg_rvalid_out  <= cfg_req_in.rd;
      fc_update_out   <= fc_upd_nxt;
      disc_exp_out    <= disc_exp_nxt;
      disc_serr_out   <= disc_exp_nxt && bctl_in[2];
      crs_exp_out     <= crs_exp_nxt;
      cpl_exp_out     <= cpl_exp_nxt;
      dt_in_order_out <= reg_r[bccr_pkg::DTORD_BIT];
      tc_out          <= reg_r[bccr_pkg::ISO_BIT] ? reg_r[bccr_pkg::TC_LSB +: 3] : 3'h0;
      loopback_out    <= reg_r[bccr_pkg::LOOP_BIT] && reverse_mode_in && test_strap_in;
    end
  end

  a_retry_sets_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rexp |=> reg_r[bccr_pkg::RSTAT_BIT]) else $error("retry expiry did not set status");
  a_flag_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (reg_r[bccr_pkg::RSTAT_BIT] && !(hit_wr && cfg_req_in.be[2] && cfg_req_in.wdata[bccr_pkg::RSTAT_BIT]))
    |=> reg_r[bccr_pkg::RSTAT_BIT]) else $error("status dropped without clear");
  a_limit_256: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (retry_in && !txn_done_in && reg_r[bccr_pkg::RLIM_LSB +: 2] == 2'b01 && rcnt_r == 32'h0000_00ff) |-> rexp)
    else $error("no expiry at 256 retries");
  a_no_limit: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (reg_r[bccr_pkg::RLIM_LSB +: 2] == 2'b00) |-> !rexp) else $error("expiry with no limit");
  a_fc_two_credits: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (credit_in && !reg_r[bccr_pkg::FC_BIT] && !fc_half_r) |=> !fc_update_out) else $error("update after one credit");
  a_short_64: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (disc_start_in && !disc_stop_in && !reg_r[bccr_pkg::DDIS_BIT] && reg_r[bccr_pkg::DSHORT_BIT])
    |=> dcnt_r == 16'h0040) else $error("short discard length not 64");
  a_disc_disabled: assert property (@(posedge core_clk_in) disable iff (rst_in)
    reg_r[bccr_pkg::DDIS_BIT] |=> !disc_exp_out) else $error("discard expiry while disabled");
  a_cpl_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cpl_start_in && !cpl_stop_in && reg_r[bccr_pkg::CPL_LSB +: 2] == 2'b11) |=> cpl_r == 22'h00_0000)
    else $error("completion timer ran while disabled");
  a_crs_25us: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (crs_start_in && !crs_stop_in && reg_r[bccr_pkg::CRS_LSB +: 2] == 2'b00) |=> crs_r == 22'h00_04e2)
    else $error("config retry 25us load wrong");
  a_tc_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !reg_r[bccr_pkg::ISO_BIT] |=> tc_out == 3'h0) else $error("traffic class not TC0");
  a_loop_forward: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !reverse_mode_in |=> !reg_r[bccr_pkg::LOOP_BIT]) else $error("loopback set in forward mode");
endmodule

/* tb/bccr_agent.sv */
// Far-side agent model: PCI target retries, freed PCIe credits and the PCI clock tick.
// Assumes it is driven from tb through its tasks, one burst at a time.
module bccr_agent (
  input  wire logic clk_in,    // Core clock
  input  wire logic rst_in,    // Async reset, high
  output logic      credit_out, // One credit freed
  output logic      retry_out,  // Target retry
  output logic      tick_out    // PCI clock tick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    credit_out = 1'b0;
    retry_out  = 1'b0;
  end
  // PCI clock modelled at core rate, so timer expectations stay in core cycles
  always @(negedge clk_in or posedge rst_in) tick_out <= !rst_in;
  task automatic send(input bit kind, input int n);
    repeat (n) begin
      @(negedge clk_in);
      if (kind) retry_out = 1'b1; else credit_out = 1'b1;
      @(negedge clk_in);
      retry_out  = 1'b0;
      credit_out = 1'b0;
    end
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the chip control register bank and the timers it steers.
// Assumes the timer parameters below are shortened; expectations derive from them.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int C1 = 40, C2 = 60, C3 = 80, P1 = 50, P2 = 70, DL = 100;
  localparam logic [31:0] BASE = 32'h0800_0000;
  logic core_clk_in, rst_in, reverse_mode_in, test_strap_in, credit_in, retry_in, txn_done_in, pci_clk_en_in;
  logic disc_start_in, disc_stop_in, crs_start_in, crs_stop_in, cpl_start_in, cpl_stop_in;
  logic cfg_rvalid_out, fc_update_out, disc_exp_out, disc_serr_out, crs_exp_out, cpl_exp_out;
  logic dt_in_order_out, loopback_out;
  logic [2:0]  bctl_in, tc_out;
  logic [31:0] cfg_rdata_out;
  bccr_pkg::bccr_cfg_req_t cfg_req_in;
  int n_mismatch, total_checks, n_fc;
  // Expiry pulse rises at the edge where the count reaches zero, N edges after the load edge
  int crs_t[4] = '{bccr_pkg::CRS_C0, C1, C2, C3};
  int cpl_t[4] = '{bccr_pkg::CPL_C0, P1, P2, 0};

  bccr_top #(.CRS_C1_P(C1), .CRS_C2_P(C2), .CRS_C3_P(C3), .CPL_C1_P(P1), .CPL_C2_P(P2), .DISC_LONG_P(DL)) DUT (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out), .reverse_mode_in(reverse_mode_in), .test_strap_in(test_strap_in),
    .bctl_in(bctl_in), .credit_in(credit_in), .fc_update_out(fc_update_out), .retry_in(retry_in),
    .txn_done_in(txn_done_in), .pci_clk_en_in(pci_clk_en_in), .disc_start_in(disc_start_in),
    .disc_stop_in(disc_stop_in), .disc_exp_out(disc_exp_out), .disc_serr_out(disc_serr_out),
    .crs_start_in(crs_start_in), .crs_stop_in(crs_stop_in), .crs_exp_out(crs_exp_out),
    .cpl_start_in(cpl_start_in), .cpl_stop_in(cpl_stop_in), .cpl_exp_out(cpl_exp_out),
    .dt_in_order_out(dt_in_order_out), .tc_out(tc_out), .loopback_out(loopback_out));
  bccr_agent agent (.clk_in(core_clk_in), .rst_in(rst_in), .credit_out(credit_in), .retry_out(retry_in),
    .tick_out(pci_clk_en_in));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (fc_update_out === 1'b1) n_fc++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge core_clk_in);
    cfg_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(negedge core_clk_in);
    cfg_req_in.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk_in);
    cfg_req_in.rd   = 1'b1;
    cfg_req_in.addr = a;
    @(negedge core_clk_in);
    cfg_req_in.rd = 1'b0;
    for (int i = 0; i < 4 && cfg_rvalid_out !== 1'b1; i++) @(negedge core_clk_in);
    chk(cfg_rvalid_out, 1'b1);
    chk(cfg_rdata_out, exp);
  endtask
  // Kind 0 discard, 1 config retry, 2 completion, 3 discard with SERR; exp 0 means never
  task automatic meas(input int k, input int exp);
    int n;
    logic hit;
    hit = 1'b0;
    @(negedge core_clk_in);
    {cpl_start_in, crs_start_in, disc_start_in} = 3'b001 << (k % 3);
    @(negedge core_clk_in);
    {cpl_start_in, crs_start_in, disc_start_in} = 3'b000;
    for (n = 1; n <= (exp ? exp + 5 : 2600); n++) begin
      @(negedge core_clk_in);
      hit = (k == 0) ? disc_exp_out : (k == 1) ? crs_exp_out : (k == 2) ? cpl_exp_out : disc_serr_out;
      if (hit === 1'b1) break;
    end
    if (exp == 0) chk(hit, 1'b0);
    else chk(n, exp);
  endtask

  initial begin
    cfg_req_in = '0;
    {reverse_mode_in, test_strap_in, txn_done_in, bctl_in} = '0;
    {disc_start_in, disc_stop_in, crs_start_in, crs_stop_in, cpl_start_in, cpl_stop_in} = '0;
    rst_in = 1'b1;
    repeat (10) @(negedge core_clk_in);
    rst_in = 1'b0;
    rd(8'h40, bccr_pkg::CC0_RESET);
    rd(8'h44, 32'h0);
    wr(8'h40, 32'hffff_ffff, 4'h8);
    rd(8'h40, 32'h3f20_0000);
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rd(8'h40, 32'h3ffe_8000);
    chk({dt_in_order_out, tc_out, loopback_out}, 5'b1_111_0);
    wr(8'h40, BASE, 4'hf);
    @(negedge core_clk_in);
    chk({dt_in_order_out, tc_out}, 4'b0_000);
    {reverse_mode_in, test_strap_in} = 2'b11;
    wr(8'h40, 32'h4c00_0000, 4'hf);
    rd(8'h40, 32'h4c00_0000);
    chk({tc_out, loopback_out}, 4'b001_1);
    {reverse_mode_in, test_strap_in} = 2'b00;
    // Flow-control grouping, two credits then one
    wr(8'h40, BASE, 4'hf);
    n_fc = 0;
    agent.send(1'b0, 4);
    repeat (2) @(negedge core_clk_in);
    chk(n_fc, 2);
    wr(8'h40, BASE | 32'h8000, 4'hf);
    n_fc = 0;
    agent.send(1'b0, 3);
    repeat (2) @(negedge core_clk_in);
    chk(n_fc, 3);
    // Retry limit 256: one short, then the expiring retry, then write-one-to-clear
    wr(8'h40, BASE | 32'h0002_0000, 4'hf);
    agent.send(1'b1, 255);
    rd(8'h40, BASE | 32'h0002_0000);
    agent.send(1'b1, 1);
    rd(8'h40, BASE | 32'h0003_0000);
    wr(8'h40, BASE | 32'h0003_0000, 4'hf);
    rd(8'h40, BASE | 32'h0002_0000);
    // A finished transaction restarts the count, so 200 then 100 retries never expire
    agent.send(1'b1, 200);
    @(negedge core_clk_in);
    txn_done_in = 1'b1;
    @(negedge core_clk_in);
    txn_done_in = 1'b0;
    agent.send(1'b1, 100);
    rd(8'h40, BASE | 32'h0002_0000);
    // Timer lengths per code
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, BASE | (32'(c) << bccr_pkg::CRS_LSB) | (32'(c) << bccr_pkg::CPL_LSB), 4'hf);
      meas(1, crs_t[c]);
      meas(2, cpl_t[c]);
    end
    wr(8'h40, BASE | 32'h0010_0000, 4'hf);
    meas(0, bccr_pkg::DISC_SHORT_CLK);
    wr(8'h40, BASE, 4'hf);
    bctl_in = 3'b101;
    meas(0, bccr_pkg::DISC_MID_CLK);
    meas(3, bccr_pkg::DISC_MID_CLK);
    bctl_in = 3'b000;
    meas(0, DL);
    reverse_mode_in = 1'b1;
    bctl_in = 3'b001;
    meas(0, DL);
    reverse_mode_in = 1'b0;
    wr(8'h40, BASE | 32'h0018_0000, 4'hf);
    meas(0, 0);
    end_sim();
  end
endmodule
